// ===== pkg/pbs_pkg.sv
package pbs_pkg;

  // Data path shape
  localparam int LANES       = 4;
  localparam int LANE_W      = 8;
  localparam int DATA_W      = LANES * LANE_W;
  localparam int FIFO_DEPTH  = 8;
  localparam int ADDR_W_DEF  = 10;

  // Clock and sleep timing, sleep figures in clock periods
  localparam int CLK_PERIOD_NS        = 100;
  localparam int SLEEP_ENTRY_PERIODS  = 2;
  localparam int SLEEP_RECOVERY_TIME  = 2;
  localparam int SLEEP_SYNC_STAGES    = SLEEP_ENTRY_PERIODS;

  // Burst counter
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;

  // Burst order strap levels
  localparam logic ORDER_LINEAR      = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic ORDER_RST         = ORDER_INTERLEAVED;

  // Lane masks
  localparam logic [LANES-1:0] LANES_ALL  = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;

  // Access state, one-hot
  typedef enum logic [2:0] {
    ST_DESEL = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } pbs_state_e;

endpackage : pbs_pkg

// ===== core/pbs_sram_port.sv
// Function
// RULE1 - Register every synchronous input and all read data on the rising edge.
// RULE2 - Burst order follows the sampled burst order strap level.
// RULE3 - Load two low address bits into a two-bit wrapping burst counter.
// RULE4 - Global write writes all four lanes, ignoring byte write controls.
// RULE5 - Read starts on strobe with selects active and writes idle.
// RULE6 - Read data appears after the next rising edge when output enabled.
// RULE7 - Access from deselected state keeps outputs floating in its first cycle.
// RULE8 - After deselect, outputs float only after the following clock rise.
// RULE9 - Processor-strobe write latches address; write controls and advance ignored.
// RULE10 - Processor-strobe write completes at second rise with global or byte lanes.
// RULE11 - Byte write changes only selected lanes, others stay unchanged.
// RULE12 - Controller raises output enable before driving write data.
// RULE13 - Data drivers are off whenever a write cycle is detected.
// RULE14 - Controller-strobe write completes in one cycle with chosen lanes.
// RULE15 - Burst advance is ignored in a controller-strobe write start cycle.
// RULE16 - Advance low steps the burst counter for reads and writes.
// RULE17 - Sleep input enters data-keeping low power; entry and exit take two cycles.
// RULE18 - Accesses pending at sleep entry are not guaranteed.
// RULE19 - Controller deselects the memory before asserting sleep.
// RULE20 - Controller keeps selects and strobes idle during sleep recovery.
// RULE21 - With both strobes low, only the processor strobe counts.
// RULE22 - Strap low selects linear, high or floating selects interleaved.
// RULE23 - Linear adds count modulo four; interleaved XORs start with count.
// RULE24 - Processor-strobe cycle is always a read, whatever write controls say.
// RULE25 - Every accepted strobe reloads the burst counter, abandoning any burst.
`timescale 1ns/10ps
`default_nettype none

// Write buffer between the pins and the memory array
module pbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store_r [DEPTH];
  logic [PTR_W:0]   wr_ptr_r;
  logic [PTR_W:0]   rd_ptr_r;
  logic             push;
  logic             pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("pbs_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  // Full when pointers differ only in the wrap bit
  assign in_ready  = (wr_ptr_r[PTR_W] == rd_ptr_r[PTR_W]) ||
                     (wr_ptr_r[PTR_W-1:0] != rd_ptr_r[PTR_W-1:0]);
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data  = store_r[rd_ptr_r[PTR_W-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage, also the capture register of write data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      store_r[wr_ptr_r[PTR_W-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  a_fifo_full_push : assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!in_ready && !pop) |=> (wr_ptr_r == $past(wr_ptr_r))) // RULE11
    else $error("write buffer accepted a word while full");
endmodule : pbs_fifo

module pbs_sram_port #(
  parameter int ADDR_W = pbs_pkg::ADDR_W_DEF
) (
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic                      primary_select_n,
  input  wire logic                      expansion_select,
  input  wire logic                      expansion_select_b_n,
  input  wire logic                      processor_addr_strobe_n,
  input  wire logic                      controller_addr_strobe_n,
  input  wire logic                      burst_advance_n,
  input  wire logic                      global_write_n,
  input  wire logic                      byte_write_enable_n,
  input  wire logic [pbs_pkg::LANES-1:0] byte_lane_select_n,
  input  wire logic                      output_enable_n,
  input  wire logic                      sleep_request,
  input  wire logic                      burst_order_strap,
  input  wire logic [pbs_pkg::DATA_W-1:0] dq_in,
  output logic      [pbs_pkg::DATA_W-1:0] dq_out,
  output logic      [pbs_pkg::DATA_W-1:0] dq_oe,
  output logic                           sleeping
);
  import pbs_pkg::*;

  localparam int ENT_W = ADDR_W + DATA_W + LANES;

  initial begin
    if (ADDR_W <= BURST_W || ADDR_W > 24) begin
      $error("pbs_sram_port: ADDR_W must lie between 3 and 24");
    end
  end

  // Next low address bits in the chosen order
  function automatic logic [BURST_W-1:0] burst_low(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] cnt,
    input logic               order
  );
    if (order == ORDER_LINEAR) begin
      burst_low = start + cnt; // RULE23
    end else begin
      burst_low = start ^ cnt; // RULE23
    end
  endfunction : burst_low

  // Lanes written by a write command
  function automatic logic [LANES-1:0] lane_mask(
    input logic             gw_n,
    input logic             bwe_n,
    input logic [LANES-1:0] sel_n
  );
    if (!gw_n) begin
      lane_mask = LANES_ALL; // RULE4
    end else if (!bwe_n) begin
      lane_mask = ~sel_n; // RULE11
    end else begin
      lane_mask = LANES_NONE;
    end
  endfunction : lane_mask

  logic [DATA_W-1:0]         mem [2**ADDR_W];
  pbs_state_e                state_r;
  pbs_state_e                state_nxt;
  logic [ADDR_W-1:0]         upper_r;
  logic [BURST_W-1:0]        start_r;
  logic [BURST_W-1:0]        cnt_r;
  logic [BURST_W-1:0]        cnt_nxt;
  logic                      order_r;
  logic [SLEEP_SYNC_STAGES-1:0] sleep_sync_r;
  logic                      sleep_r;
  logic                      drive_r;
  logic [DATA_W-1:0]         dq_out_r;
  logic                      chips_on;
  logic                      psp_take;
  logic                      csc_take;
  logic                      strobe;
  logic [LANES-1:0]          lanes;
  logic                      wr_ctl;
  logic                      rd_start;
  logic                      wc_start;
  logic                      cont;
  logic                      cont_wr;
  logic                      step;
  logic                      write_seen;
  logic [ADDR_W-1:0]         cur_addr;
  logic [ADDR_W-1:0]         next_addr;
  logic [ADDR_W-1:0]         wr_addr;
  logic                      push_valid;
  logic                      push_ready;
  logic [ENT_W-1:0]          push_data;
  logic                      pop_valid;
  logic                      pop_ready;
  logic [ENT_W-1:0]          pop_data;

  // Sleep synchroniser, two edges to enter or leave
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_sync_r <= '0;
    end else begin
      sleep_sync_r <= {sleep_sync_r[SLEEP_SYNC_STAGES-2:0], sleep_request};
    end
  end
  assign sleep_r  = sleep_sync_r[SLEEP_SYNC_STAGES-1]; // RULE17
  assign sleeping = sleep_r;

  // Burst order strap sampled every edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      order_r <= ORDER_RST;
    end else begin
      order_r <= burst_order_strap; // RULE2 RULE22
    end
  end

  // Command decode of the pin levels at this edge
  assign chips_on = ~primary_select_n & expansion_select &
                    ~expansion_select_b_n;
  assign psp_take = ~processor_addr_strobe_n & ~primary_select_n &
                    ~sleep_r; // RULE5
  assign csc_take = ~controller_addr_strobe_n & ~psp_take &
                    ~sleep_r; // RULE21
  assign strobe   = psp_take | csc_take;
  assign lanes    = lane_mask(global_write_n, byte_write_enable_n,
                              byte_lane_select_n);
  assign wr_ctl   = (lanes != LANES_NONE);
  assign rd_start = chips_on & (psp_take | (csc_take & ~wr_ctl)); // RULE24
  assign wc_start = chips_on & csc_take & wr_ctl; // RULE14
  assign cont     = ~strobe & ~sleep_r & (state_r != ST_DESEL);
  assign cont_wr  = cont & wr_ctl; // RULE10
  assign step     = cont & ~burst_advance_n; // RULE16 RULE15 RULE9

  // Burst addresses from the counter
  assign cnt_nxt   = step ? cnt_r + 1'b1 : cnt_r;
  assign cur_addr  = {upper_r[ADDR_W-1:BURST_W],
                      burst_low(start_r, cnt_r, order_r)};
  assign next_addr = {upper_r[ADDR_W-1:BURST_W],
                      burst_low(start_r, cnt_nxt, order_r)};
  assign wr_addr   = wc_start ? addr : next_addr;

  // Address register and burst counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_r <= '0;
      start_r <= BURST_CNT_RST;
      cnt_r   <= BURST_CNT_RST;
    end else if (strobe && chips_on) begin
      upper_r <= addr; // RULE1 RULE25
      start_r <= addr[BURST_W-1:0]; // RULE3
      cnt_r   <= BURST_CNT_RST;
    end else if (cont) begin
      cnt_r   <= cnt_nxt; // RULE16
    end
  end

  // Access state
  always_comb begin
    state_nxt = state_r;
    if (sleep_r) begin
      state_nxt = ST_DESEL; // RULE18
    end else if (strobe && !chips_on) begin
      state_nxt = ST_DESEL;
    end else if (rd_start) begin
      state_nxt = ST_READ;
    end else if (wc_start) begin
      state_nxt = ST_WRITE;
    end else if (cont) begin
      state_nxt = cont_wr ? ST_WRITE : ST_READ;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_DESEL;
    end else begin
      case (state_r)
        ST_DESEL: state_r <= state_nxt;
        ST_READ:  state_r <= state_nxt;
        ST_WRITE: state_r <= state_nxt;
        default:  state_r <= ST_DESEL;
      endcase
    end
  end

  // Write buffer fed straight from the pins
  assign push_valid = wc_start | cont_wr;
  assign push_data  = {wr_addr, dq_in, lanes};
  assign pop_ready  = ~sleep_r;

  pbs_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // Memory array, lane-wise self-timed write
  always_ff @(posedge sys_clk) begin
    if (pop_valid && pop_ready) begin
      for (int i = 0; i < LANES; i++) begin
        if (pop_data[i]) begin
          mem[pop_data[ENT_W-1 -: ADDR_W]][i*LANE_W +: LANE_W] <=
            pop_data[LANES + i*LANE_W +: LANE_W]; // RULE11
        end
      end
    end
  end

  // Output register and pipelined output enable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dq_out_r <= '0;
      drive_r  <= 1'b0;
    end else begin
      if (!sleep_r) begin
        dq_out_r <= mem[cur_addr]; // RULE1 RULE6
      end
      drive_r  <= (state_r == ST_READ) & ~sleep_r; // RULE7 RULE8
    end
  end

  // Drivers masked by write detection and output enable
  assign write_seen = (state_r == ST_WRITE) |
                      ((state_r != ST_DESEL) & wr_ctl & ~strobe);
  assign dq_out = dq_out_r;
  assign dq_oe  = {DATA_W{drive_r & ~output_enable_n & ~write_seen}}; // RULE13

  // Checks
  sequence s_read_taken;
    rd_start && !sleep_r;
  endsequence

  sequence s_addr_loaded;
    ##1 (cur_addr == {$past(addr[ADDR_W-1:BURST_W]), $past(addr[1:0])});
  endsequence

  a_read_data_out : assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_read_taken |-> s_addr_loaded ##1 (dq_out == $past(mem[cur_addr]))) // RULE6
    else $error("read data not in output register one edge later");
  a_global_lanes : assert property (@(posedge sys_clk) disable iff (!reset_n)
    (push_valid && !global_write_n) |-> (push_data[LANES-1:0] == LANES_ALL)) // RULE4
    else $error("global write did not select every lane");
  a_byte_lanes : assert property (@(posedge sys_clk) disable iff (!reset_n)
    (push_valid && global_write_n) |->
      (push_data[LANES-1:0] == ~byte_lane_select_n)) // RULE10
    else $error("byte write lanes differ from lane selects");
  a_psp_is_read : assert property (@(posedge sys_clk) disable iff (!reset_n)
    (psp_take && chips_on) |-> !push_valid ##1 (state_r == ST_READ)) // RULE24
    else $error("processor strobe cycle was not a read");
  a_psp_ignored : assert property (@(posedge sys_clk) disable iff (!reset_n)
    (primary_select_n && controller_addr_strobe_n) |=>
      ($stable(upper_r) && $stable(start_r))) // RULE5
    else $error("processor strobe acted while primary select high");
  a_first_float : assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == ST_DESEL && rd_start) |=> (dq_oe == '0)) // RULE7
    else $error("outputs driven in first cycle after deselect");
  a_double_desel : assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == ST_READ && strobe && !chips_on && !sleep_r) |=>
      (drive_r ##1 !drive_r)) // RULE8
    else $error("deselect did not float outputs one edge later");
  a_write_float : assert property (@(posedge sys_clk) disable iff (!reset_n)
    write_seen |-> (dq_oe == '0)) // RULE13
    else $error("data driven during a write cycle");
  a_controller_addr_strobe_n_one_cycle : assert property (@(posedge sys_clk) disable iff (!reset_n)
    wc_start |-> (push_valid && push_data[ENT_W-1 -: ADDR_W] == addr)
      ##1 (state_r == ST_WRITE && cnt_r == BURST_CNT_RST)) // RULE14 RULE15
    else $error("controller strobe write not taken in one cycle");
  a_burst_step : assert property (@(posedge sys_clk) disable iff (!reset_n)
    step |=> (cnt_r == $past(cnt_r) + 2'h1)) // RULE16
    else $error("burst counter did not step on advance");
  a_sleep_enter : assert property (@(posedge sys_clk) disable iff (!reset_n)
    sleep_request [*2] |=> (sleeping && state_r == ST_DESEL)) // RULE17
    else $error("sleep not entered after two edges");
endmodule : pbs_sram_port

`default_nettype wire

// ===== test/pbs_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

// Controller side of the shared data lines
module pbs_ctrl_model (
  input  wire logic                       sys_clk,
  input  wire logic                       drive,
  input  wire logic [pbs_pkg::DATA_W-1:0] wdata,
  input  wire logic                       oe_req_n,
  input  wire logic [pbs_pkg::DATA_W-1:0] dq_out,
  input  wire logic [pbs_pkg::DATA_W-1:0] dq_oe,
  output logic                            output_enable_n,
  output logic      [pbs_pkg::DATA_W-1:0] dq_bus
);
  import pbs_pkg::*;

  logic [DATA_W-1:0] last_r;

  // Memory drivers released whenever the controller drives
  assign output_enable_n = drive | oe_req_n;

  // Wire level; a released line never keeps its last value
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      if (dq_oe[i]) dq_bus[i] = dq_out[i];
      else if (drive) dq_bus[i] = wdata[i];
      else dq_bus[i] = ~last_r[i];
    end
  end

  // Last wire level
  always_ff @(posedge sys_clk) last_r <= dq_bus;
endmodule : pbs_ctrl_model

`default_nettype wire

// ===== test/pbs_sram_port_test.sv
`timescale 1ns/10ps
`default_nettype none

module pbs_sram_port_test;
  import pbs_pkg::*;
  localparam int AW = ADDR_W_DEF;

  logic              clk, rst_n, sel_n, ex_sel, ex_b_n, sp_n, sc_n, adv_n;
  logic              gw_n, bwe_n, oe_req, slp_req, strap, drv, slp;
  logic [LANES-1:0]  bl_n;
  logic [AW-1:0]     a, b;
  logic [DATA_W-1:0] wd, dq_bus, dq_out, dq_oe;
  logic [31:0]       seed, r;
  wire               oe_n;
  logic [DATA_W-1:0] mem [0:(1<<AW)-1];
  int                errors, checks_done;

  pbs_sram_port u_dut (.sys_clk(clk), .reset_n(rst_n), .addr(a),
    .primary_select_n(sel_n), .expansion_select(ex_sel),
    .expansion_select_b_n(ex_b_n), .processor_addr_strobe_n(sp_n),
    .controller_addr_strobe_n(sc_n), .burst_advance_n(adv_n),
    .global_write_n(gw_n), .byte_write_enable_n(bwe_n),
    .byte_lane_select_n(bl_n), .output_enable_n(oe_n),
    .sleep_request(slp_req), .burst_order_strap(strap), .dq_in(dq_bus),
    .dq_out(dq_out), .dq_oe(dq_oe), .sleeping(slp));

  pbs_ctrl_model u_ctrl (.sys_clk(clk), .drive(drv), .wdata(wd),
    .oe_req_n(oe_req), .dq_out(dq_out), .dq_oe(dq_oe),
    .output_enable_n(oe_n), .dq_bus(dq_bus));

  // Clock
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS/2) clk = ~clk;
  end

  // Burst beat address
  function automatic logic [1:0] beat(input logic [1:0] s,
                                      input logic [1:0] n, input logic o);
    beat = (o == ORDER_INTERLEAVED) ? (s ^ n) : (s + n);
  endfunction : beat

  // Word after a write with global or per-lane control
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] d, input logic g_n, input logic [LANES-1:0] l_n);
    merge = old;
    for (int i = 0; i < LANES; i++) begin
      if (!g_n || !l_n[i]) merge[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    end
  endfunction : merge

  task automatic chk(input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask : step

  task automatic idle();
    sp_n = 1'b1;
    sc_n = 1'b1;
    adv_n = 1'b1;
    gw_n = 1'b1;
    bwe_n = 1'b1;
    bl_n = 4'hF;
    drv = 1'b0;
  endtask : idle

  // One-cycle write by the controller strobe
  task automatic csc_wr(input logic [AW-1:0] ad, input logic [DATA_W-1:0] d,
                        input logic g_n, input logic [LANES-1:0] l_n);
    sc_n = 1'b0;
    a = ad;
    wd = d;
    drv = 1'b1;
    gw_n = g_n;
    bwe_n = g_n ? 1'b0 : 1'($random(seed));
    bl_n = l_n;
    adv_n = 1'($random(seed));
    step();
    chk(dq_oe, 32'h0000_0000);
    mem[ad] = merge(mem[ad], d, g_n, l_n);
    idle();
  endtask : csc_wr

  // Strobe cycle read first, then a byte write in the second cycle
  task automatic psp_wr(input logic [AW-1:0] ad, input logic [DATA_W-1:0] d,
                        input logic [LANES-1:0] l_n);
    sp_n = 1'b0;
    sc_n = 1'b0;
    a = ad;
    gw_n = 1'b0;
    adv_n = 1'b0;
    wd = ~d;
    drv = 1'b1;
    step();
    idle();
    drv = 1'b1;
    bwe_n = 1'b0;
    bl_n = l_n;
    wd = d;
    a = ~ad;
    step();
    mem[ad] = merge(mem[ad], d, 1'b1, l_n);
    idle();
  endtask : psp_wr

  // Read burst of n beats with the counter stepping each cycle
  task automatic rd(input logic [AW-1:0] ad, input logic o, input int n,
                    input logic fresh);
    logic [AW-1:0] x;
    strap = o;
    oe_req = 1'b0;
    step();
    sp_n = 1'b0;
    a = ad;
    step();
    if (fresh) chk(dq_oe, 32'h0000_0000);
    sp_n = 1'b1;
    adv_n = 1'b0;
    a = ~ad;
    for (int k = 0; k < n; k++) begin
      step();
      x = {ad[AW-1:2], beat(ad[1:0], 2'(k), o)};
      chk(dq_out, mem[x]);
      chk(dq_oe, 32'hFFFF_FFFF);
    end
    idle();
  endtask : rd

  // Deselect by strobe; drivers stay one more cycle
  task automatic desel();
    sp_n = 1'b0;
    ex_sel = 1'b0;
    step();
    chk(dq_oe, 32'hFFFF_FFFF);
    sp_n = 1'b1;
    step();
    chk(dq_oe, 32'h0000_0000);
    ex_sel = 1'b1;
  endtask : desel

  // Main sequence
  initial begin
    seed = 32'h67e7;
    errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    sel_n = 1'b0;
    ex_sel = 1'b1;
    ex_b_n = 1'b0;
    oe_req = 1'b1;
    slp_req = 1'b0;
    strap = ORDER_RST;
    a = '0;
    wd = '0;
    b = '0;
    idle();
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk(dq_oe, 32'h0000_0000);
    chk(dq_out, 32'h0000_0000);
    chk(32'(slp), 32'h0000_0000);
    rst_n = 1'b1;
    step();
    for (int g = 0; g < 16; g++) begin
      b = AW'($random(seed));
      for (int k = 0; k < 4; k++) begin
        csc_wr({b[AW-1:2], 2'(k)}, $random(seed), 1'b0, 4'hF);
      end
      r = $random(seed);
      csc_wr({b[AW-1:2], r[1:0]}, $random(seed), r[2], r[6:3]);
      psp_wr({b[AW-1:2], r[8:7]}, $random(seed), r[12:9]);
      rd({b[AW-1:2], 2'(g >> 1)}, g[0], g < 8 ? 4 : 1 + r[14:13], 1'b0);
    end
    desel();
    rd({b[AW-1:2], 2'h1}, ORDER_LINEAR, 4, 1'b1);
    desel();
    slp_req = 1'b1;
    step();
    chk(32'(slp), 32'h0000_0000);
    step();
    chk(32'(slp), 32'h0000_0001);
    slp_req = 1'b0;
    step();
    chk(32'(slp), 32'h0000_0001);
    step();
    chk(32'(slp), 32'h0000_0000);
    repeat (SLEEP_RECOVERY_TIME) step();
    rd({b[AW-1:2], 2'h2}, ORDER_INTERLEAVED, 4, 1'b1);
    end_sim();
  end

  // Hang guard
  initial begin
    #(100000 * CLK_PERIOD_NS);
    errors++;
    end_sim();
  end
endmodule : pbs_sram_port_test

`default_nettype wire
